// *** inc/aarc_pkg.sv ***
// Shared constants and types for the auxiliary converter readback block
package aarc_pkg;

  // Memory-access map
  localparam int          ADDR_W         = 10;
  localparam int          DATA_W         = 8;
  localparam logic [9:0]  RX_PWRDN_ADDR  = 10'h324;
  localparam logic [9:0]  AUX_PWRDN_ADDR = 10'h325;
  localparam logic [9:0]  RES_UPPER_ADDR = 10'h327;
  localparam logic [9:0]  RES_LOWER_ADDR = 10'h328;
  localparam logic [9:0]  IN_SEL_ADDR    = 10'h359;

  // Reset values and unmapped read data
  localparam logic [7:0]  RX_PWRDN_RST   = 8'h00;
  localparam logic [7:0]  AUX_PWRDN_RST  = 8'h00;
  localparam logic [7:0]  IN_SEL_RST     = 8'h00;
  localparam logic [7:0]  UNMAPPED_DATA  = 8'h00;

  // Field positions
  localparam int          ADC_EN_BIT     = 4;
  localparam int          TEMP_EN_BIT    = 1;
  localparam int          SEL_LSB        = 2;
  localparam int          SEL_W          = 2;
  localparam int          LOW_BITS       = 2;

  // Input-select codes
  localparam logic [1:0]  SEL_RSSI       = 2'h0;
  localparam logic [1:0]  SEL_EXT        = 2'h1;
  localparam logic [1:0]  SEL_TEMP       = 2'h2;

  // Conversion timing
  localparam int          RES_W          = 8;
  localparam int          CLK_PERIOD_NS  = 8;
  localparam int          CONV_TIME_NS   = 1000;
  localparam int          CONV_CYC       = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int          BIT_CYC        = CONV_CYC / RES_W;

  typedef enum logic [1:0] {
    radio_off_state,
    radio_idle_state,
    radio_receive_state,
    radio_transmit_state
  } aarc_radio_t;

  typedef enum logic [1:0] {
    RB_IDLE,
    RB_CONV,
    RB_LOW,
    RB_HIGH
  } aarc_rb_state_t;

endpackage : aarc_pkg

// *** inc/aarc_conv_if.sv ***
// Link between readback control and the successive-approximation core
`timescale 1ns/1ns
interface aarc_conv_if;
  logic       start;
  logic       enable;
  logic [7:0] level;
  logic       busy;
  logic       done;
  logic [7:0] result;

  modport ctl  (output start, output enable, output level, input busy, input done, input result);
  modport conv (input start, input enable, input level, output busy, output done, output result);
endinterface : aarc_conv_if

// *** hw/aarc_src_mux.sv ***
// Converter input source selection
`timescale 1ns/1ns
module aarc_src_mux (
  input  wire logic       rx_active,
  input  wire logic       temp_powered,
  input  wire logic [1:0] sel,
  input  wire logic [7:0] temp_level,
  input  wire logic [7:0] rssi_level,
  input  wire logic [7:0] ext_level,
  output logic      [7:0] level
);
  always_comb begin
    if (rx_active) begin
      level = rssi_level;
    end else if (sel == aarc_pkg::SEL_TEMP) begin
      // Unpowered sensor reads as ground
      level = temp_powered ? temp_level : 8'h00;
    end else if (sel == aarc_pkg::SEL_EXT) begin
      level = ext_level;
    end else begin
      level = rssi_level;
    end
  end
endmodule : aarc_src_mux

// *** hw/aarc_sar_conv.sv ***
// Successive-approximation core, one result bit per divider tick
`timescale 1ns/1ns
module aarc_sar_conv #(
  parameter int BIT_CYC = aarc_pkg::BIT_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  aarc_conv_if.conv cif
);
  localparam logic [7:0] DIV_LAST = 8'(BIT_CYC - 1);

  logic       busy_q, busy_d;
  logic       done_q, done_d;
  logic [7:0] acc_q,  acc_d;
  logic [7:0] res_q,  res_d;
  logic [2:0] idx_q,  idx_d;
  logic [7:0] div_q,  div_d;
  logic [7:0] trial;

  always_comb begin
    busy_d = busy_q;
    done_d = 1'b0;
    acc_d  = acc_q;
    res_d  = res_q;
    idx_d  = idx_q;
    div_d  = div_q;
    trial  = acc_q | (8'h01 << idx_q);
    if (!busy_q) begin
      if (cif.start) begin
        busy_d = 1'b1;
        idx_d  = 3'h7;
        div_d  = 8'h00;
        acc_d  = 8'h00;
      end
    end else if (div_q == DIV_LAST) begin
      div_d = 8'h00;
      if (cif.level >= trial) begin
        acc_d = trial;
      end
      if (idx_q == 3'h0) begin
        busy_d = 1'b0;
        done_d = 1'b1;
        // A powered-down converter yields zero rather than noise
        res_d  = cif.enable ? acc_d : 8'h00;
      end else begin
        idx_d = idx_q - 3'h1;
      end
    end else begin
      div_d = div_q + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      acc_q  <= 8'h00;
      res_q  <= 8'h00;
      idx_q  <= 3'h0;
      div_q  <= 8'h00;
    end else begin
      busy_q <= busy_d;
      done_q <= done_d;
      acc_q  <= acc_d;
      res_q  <= res_d;
      idx_q  <= idx_d;
      div_q  <= div_d;
    end
  end

  assign cif.busy   = busy_q;
  assign cif.done   = done_q;
  assign cif.result = res_q;

  property p_conv_time;
    @(posedge clk) disable iff (rst)
    (cif.start && !busy_q) |-> ##[100:130] done_q;
  endproperty
  a_conv_time: assert property (p_conv_time) else $error("conversion not done in about 1 us");
endmodule : aarc_sar_conv

// *** hw/aarc_top.sv ***
// Auxiliary converter control and three-read sample readback
//
// Summary of operation
// - One conversion takes about one microsecond after it is requested.
// - Each sample is an 8-bit unsigned value split over two locations.
// - The input-select register at 0x359 chooses the converter source.
// - In receive state the source is forced to the signal-strength level.
// - In receive state the converter is powered without any host write.
// - Reading 0x327 first starts a readback and captures a fresh sample.
// - Next, reading 0x328 returns the two low sample bits.
// - Then reading 0x327 again returns the six high sample bits.
`timescale 1ns/1ns
module aarc_top #(
  parameter int BIT_CYC = aarc_pkg::BIT_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic [aarc_pkg::ADDR_W-1:0] mem_addr,
  input  wire logic                       mem_rd,
  input  wire logic                       mem_wr,
  input  wire logic [7:0]                 mem_wdata,
  output logic      [7:0]                 mem_rdata,
  output logic                            mem_rvalid,
  input  wire aarc_pkg::aarc_radio_t      radio_state,
  input  wire logic [7:0]                 temp_level,
  input  wire logic [7:0]                 rssi_level,
  input  wire logic [7:0]                 ext_level,
  output logic                            adc_powered,
  output logic                            temp_powered,
  output logic                            readback_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  logic rx_active;
  logic rd_upper;
  logic rd_lower;

  assign rx_active = (radio_state == aarc_pkg::radio_receive_state);
  assign rd_upper  = mem_rd && (mem_addr == aarc_pkg::RES_UPPER_ADDR);
  assign rd_lower  = mem_rd && (mem_addr == aarc_pkg::RES_LOWER_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [7:0] rx_pd_q,  rx_pd_d;
  logic [7:0] aux_pd_q, aux_pd_d;
  logic [7:0] sel_q,    sel_d;
  logic       adc_pw_q, adc_pw_d;
  logic       tmp_pw_q, tmp_pw_d;

  always_comb begin
    rx_pd_d  = rx_pd_q;
    aux_pd_d = aux_pd_q;
    sel_d    = sel_q;
    if (mem_wr) begin
      if (mem_addr == aarc_pkg::RX_PWRDN_ADDR) begin
        rx_pd_d = mem_wdata;
      end else if (mem_addr == aarc_pkg::AUX_PWRDN_ADDR) begin
        aux_pd_d = mem_wdata;
      end else if (mem_addr == aarc_pkg::IN_SEL_ADDR) begin
        sel_d = mem_wdata;
      end
    end
    // Receive state powers the converter on its own
    adc_pw_d = rx_active || rx_pd_q[aarc_pkg::ADC_EN_BIT];
    tmp_pw_d = aux_pd_q[aarc_pkg::TEMP_EN_BIT];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_pd_q  <= aarc_pkg::RX_PWRDN_RST;
      aux_pd_q <= aarc_pkg::AUX_PWRDN_RST;
      sel_q    <= aarc_pkg::IN_SEL_RST;
      adc_pw_q <= 1'b0;
      tmp_pw_q <= 1'b0;
    end else begin
      rx_pd_q  <= rx_pd_d;
      aux_pd_q <= aux_pd_d;
      sel_q    <= sel_d;
      adc_pw_q <= adc_pw_d;
      tmp_pw_q <= tmp_pw_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source selection and converter core

  aarc_conv_if cif ();
  logic [7:0] conv_level;

  aarc_src_mux u_mux (
    .rx_active    (rx_active),
    .temp_powered (tmp_pw_q),
    .sel          (sel_q[aarc_pkg::SEL_LSB +: aarc_pkg::SEL_W]),
    .temp_level   (temp_level),
    .rssi_level   (rssi_level),
    .ext_level    (ext_level),
    .level        (conv_level)
  );

  aarc_sar_conv #(
    .BIT_CYC (BIT_CYC)
  ) u_conv (
    .clk (clk),
    .rst (rst),
    .cif (cif.conv)
  );

  assign cif.level  = conv_level;
  assign cif.enable = adc_pw_q;

  ////////////////////////////////////////////////////////////////////////////
  // Readback sequencer

  aarc_pkg::aarc_rb_state_t rb_q, rb_d;
  logic       start_q, start_d;
  logic [7:0] held_q,  held_d;

  always_comb begin
    rb_d    = rb_q;
    start_d = 1'b0;
    held_d  = held_q;
    case (rb_q)
      aarc_pkg::RB_IDLE: begin
        if (rd_upper) begin
          start_d = 1'b1;
          rb_d    = aarc_pkg::RB_CONV;
        end
      end
      aarc_pkg::RB_CONV: begin
        // Upper reads here are ignored; the sample is still forming
        if (cif.done) begin
          held_d = cif.result;
          rb_d   = aarc_pkg::RB_LOW;
        end
      end
      aarc_pkg::RB_LOW: begin
        if (rd_lower) begin
          rb_d = aarc_pkg::RB_HIGH;
        end else if (rd_upper) begin
          rb_d = aarc_pkg::RB_IDLE;
        end
      end
      aarc_pkg::RB_HIGH: begin
        if (rd_upper) begin
          rb_d = aarc_pkg::RB_IDLE;
        end
      end
      default: begin
        rb_d = aarc_pkg::RB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rb_q    <= aarc_pkg::RB_IDLE;
      start_q <= 1'b0;
      held_q  <= 8'h00;
    end else begin
      rb_q    <= rb_d;
      start_q <= start_d;
      held_q  <= held_d;
    end
  end

  assign cif.start = start_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read data path

  logic [7:0] rdata_q,  rdata_d;
  logic       rvalid_q, rvalid_d;
  logic       busy_q,   busy_d;

  always_comb begin
    rvalid_d = mem_rd;
    rdata_d  = aarc_pkg::UNMAPPED_DATA;
    if (mem_addr == aarc_pkg::RES_UPPER_ADDR) begin
      rdata_d = {held_q[7:aarc_pkg::LOW_BITS], 2'b00};
    end else if (mem_addr == aarc_pkg::RES_LOWER_ADDR) begin
      rdata_d = {6'h00, held_q[aarc_pkg::LOW_BITS-1:0]};
    end else if (mem_addr == aarc_pkg::RX_PWRDN_ADDR) begin
      rdata_d = rx_pd_q;
    end else if (mem_addr == aarc_pkg::AUX_PWRDN_ADDR) begin
      rdata_d = aux_pd_q;
    end else if (mem_addr == aarc_pkg::IN_SEL_ADDR) begin
      rdata_d = sel_q;
    end
    if (!mem_rd) begin
      rdata_d = rdata_q;
    end
    busy_d = (rb_d == aarc_pkg::RB_CONV);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
      busy_q   <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      busy_q   <= busy_d;
    end
  end

  assign mem_rdata     = rdata_q;
  assign mem_rvalid    = rvalid_q;
  assign adc_powered   = adc_pw_q;
  assign temp_powered  = tmp_pw_q;
  assign readback_busy = busy_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_src_sel;
    @(posedge clk) disable iff (rst)
    (!rx_active && sel_q[3:2] == aarc_pkg::SEL_EXT) |-> conv_level == ext_level;
  endproperty
  a_src_sel: assert property (p_src_sel) else $error("external source not routed");

  property p_rx_force;
    @(posedge clk) disable iff (rst)
    rx_active |-> conv_level == rssi_level;
  endproperty
  a_rx_force: assert property (p_rx_force) else $error("receive state did not force rssi source");

  property p_rx_power;
    @(posedge clk) disable iff (rst)
    rx_active |=> adc_powered;
  endproperty
  a_rx_power: assert property (p_rx_power) else $error("converter not powered in receive");

  property p_start;
    @(posedge clk) disable iff (rst)
    (rd_upper && rb_q == aarc_pkg::RB_IDLE) |=> (cif.start && readback_busy) ##1 !cif.start;
  endproperty
  a_start: assert property (p_start) else $error("upper read did not start one conversion");

  property p_capture;
    @(posedge clk) disable iff (rst)
    (cif.done && rb_q == aarc_pkg::RB_CONV) |=> (held_q == $past(cif.result) && rb_q == aarc_pkg::RB_LOW);
  endproperty
  a_capture: assert property (p_capture) else $error("sample not captured on done");

  property p_low_read;
    @(posedge clk) disable iff (rst)
    (rd_lower && rb_q == aarc_pkg::RB_LOW) |=> (mem_rvalid && mem_rdata == {6'h00, held_q[1:0]}
      && rb_q == aarc_pkg::RB_HIGH);
  endproperty
  a_low_read: assert property (p_low_read) else $error("lower read returned wrong bits");

  property p_high_read;
    @(posedge clk) disable iff (rst)
    (rd_upper && rb_q == aarc_pkg::RB_HIGH) |=> (mem_rdata == {held_q[7:2], 2'b00} && rb_q == aarc_pkg::RB_IDLE);
  endproperty
  a_high_read: assert property (p_high_read) else $error("final upper read returned wrong bits");

  property p_hold;
    @(posedge clk) disable iff (rst)
    (rb_q == aarc_pkg::RB_LOW || rb_q == aarc_pkg::RB_HIGH) |=> $stable(held_q);
  endproperty
  a_hold: assert property (p_hold) else $error("held sample changed mid readback");

  property p_busy_end;
    @(posedge clk) disable iff (rst)
    (cif.done && rb_q == aarc_pkg::RB_CONV) |=> !readback_busy;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy still set after conversion end");

  // A late upper read during conversion must not launch a second one
  property p_no_restart;
    @(posedge clk) disable iff (rst)
    (rd_upper && rb_q == aarc_pkg::RB_CONV) |=> !cif.start;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("conversion restarted mid readback");

  property p_adc_off;
    @(posedge clk) disable iff (rst)
    (!rx_active && !rx_pd_q[aarc_pkg::ADC_EN_BIT]) |=> !adc_powered;
  endproperty
  a_adc_off: assert property (p_adc_off) else $error("converter powered without enable");

  property p_temp_power;
    @(posedge clk) disable iff (rst)
    (mem_wr && mem_addr == aarc_pkg::AUX_PWRDN_ADDR && mem_wdata[aarc_pkg::TEMP_EN_BIT]) |=> ##1 temp_powered;
  endproperty
  a_temp_power: assert property (p_temp_power) else $error("sensor not powered after write");

  property p_sel_write;
    @(posedge clk) disable iff (rst)
    (mem_wr && mem_addr == aarc_pkg::IN_SEL_ADDR) |=> sel_q == $past(mem_wdata);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("input select not written");

endmodule : aarc_top

// *** testbench/aarc_host.sv ***
// Host model issuing memory-access reads and writes to the converter block
`timescale 1ns/1ns
module aarc_host (
  input  wire logic       clk,
  output logic      [9:0] mem_addr,
  output logic            mem_rd,
  output logic            mem_wr,
  output logic      [7:0] mem_wdata,
  input  wire logic [7:0] mem_rdata,
  input  wire logic       mem_rvalid,
  input  wire logic       readback_busy
);
  initial begin
    mem_addr  = 10'h3FF;
    mem_rd    = 1'b0;
    mem_wr    = 1'b0;
    mem_wdata = 8'hA5;
  end

  // Released lines show the inverse so stale values never look valid
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    mem_addr  <= a;
    mem_wdata <= d;
    mem_wr    <= 1'b1;
    @(posedge clk);
    mem_wr    <= 1'b0;
    mem_addr  <= ~a;
    mem_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    mem_addr <= a;
    mem_rd   <= 1'b1;
    @(posedge clk);
    mem_rd   <= 1'b0;
    mem_addr <= ~a;
    @(posedge clk);
    v = mem_rvalid;
    d = mem_rdata;
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  // First upper read only starts; its data belongs to the old sample
  task automatic start_conv(output int cyc);
    logic [7:0] d;
    logic       v;
    rd(aarc_pkg::RES_UPPER_ADDR, d, v);
    cyc = 0;
    while (readback_busy === 1'b1 && cyc < 1000) begin
      @(posedge clk);
      cyc++;
    end
  endtask : start_conv

  task automatic fetch(output logic [7:0] lo, output logic [7:0] hi);
    logic v;
    rd(aarc_pkg::RES_LOWER_ADDR, lo, v);
    rd(aarc_pkg::RES_UPPER_ADDR, hi, v);
  endtask : fetch

  // Converter first, then sensor, then source select
  task automatic temp_setup();
    wr(aarc_pkg::RX_PWRDN_ADDR, 8'h10);
    wr(aarc_pkg::AUX_PWRDN_ADDR, 8'h02);
    wr(aarc_pkg::IN_SEL_ADDR, 8'h08);
  endtask : temp_setup

  function automatic real celsius(input logic [7:0] s, input logic [7:0] cal, input real t_cal);
    return 0.9474 * (real'(s) - real'(cal)) + t_cal;
  endfunction : celsius
endmodule : aarc_host

// *** testbench/tb.sv ***
// Self-checking bench for the converter readback block
`timescale 1ns/1ns
module tb;
  logic                  clk;
  logic                  rst;
  logic [9:0]            mem_addr;
  logic                  mem_rd;
  logic                  mem_wr;
  logic [7:0]            mem_wdata;
  logic [7:0]            mem_rdata;
  logic                  mem_rvalid;
  aarc_pkg::aarc_radio_t radio_state;
  logic [7:0]            temp_level;
  logic [7:0]            rssi_level;
  logic [7:0]            ext_level;
  logic                  adc_powered;
  logic                  temp_powered;
  logic                  readback_busy;
  int                    err_count;
  int                    n_tests;
  int                    cyc_count;
  logic [7:0]            sel_reg;
  logic [7:0]            pd_reg;
  logic [7:0]            aux_reg;
  logic [7:0]            d;
  logic                  v;

  aarc_top u_dut (.clk(clk), .rst(rst), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .radio_state(radio_state),
    .temp_level(temp_level), .rssi_level(rssi_level), .ext_level(ext_level), .adc_powered(adc_powered),
    .temp_powered(temp_powered), .readback_busy(readback_busy));

  aarc_host u_host (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .readback_busy(readback_busy));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic close_out();
    $display("errors=%0d compares=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  // Limit covers about fifteen readbacks with wide margin
  always @(posedge clk) begin
    cyc_count++;
    if (cyc_count == 10000) begin
      err_count++;
      close_out();
    end
  end

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check8

  function automatic logic [7:0] exp_sample();
    if (radio_state == aarc_pkg::radio_receive_state) return rssi_level;
    if (pd_reg[aarc_pkg::ADC_EN_BIT] !== 1'b1) return 8'h00;
    case (sel_reg[3:2])
      aarc_pkg::SEL_EXT:  return ext_level;
      aarc_pkg::SEL_TEMP: return aux_reg[aarc_pkg::TEMP_EN_BIT] ? temp_level : 8'h00;
      default:            return rssi_level;
    endcase
  endfunction : exp_sample

  task automatic set_levels();
    @(posedge clk);
    temp_level <= 8'($urandom);
    rssi_level <= 8'($urandom);
    ext_level  <= 8'($urandom);
    @(posedge clk);
  endtask : set_levels

  // Disturb moves all sources after capture; the sample must not follow
  task automatic do_rb(input logic disturb);
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] exp;
    int         cyc;
    set_levels();
    exp = exp_sample();
    u_host.start_conv(cyc);
    check8({7'h0, cyc >= 8 * aarc_pkg::BIT_CYC - 8 && cyc <= 8 * aarc_pkg::BIT_CYC + 8}, 8'h01);
    if (disturb) set_levels();
    u_host.fetch(lo, hi);
    check8({hi[7:2], lo[1:0]}, exp);
    check8({lo[7:2], hi[1:0]}, 8'h00);
  endtask : do_rb

  task automatic wr_reg(input logic [9:0] a, input logic [7:0] val);
    u_host.wr(a, val);
    if (a == aarc_pkg::RX_PWRDN_ADDR) pd_reg = val;
    if (a == aarc_pkg::IN_SEL_ADDR) sel_reg = val;
    if (a == aarc_pkg::AUX_PWRDN_ADDR) aux_reg = val;
  endtask : wr_reg

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [9:0] addrs [4];
    aarc_pkg::aarc_radio_t st [4];
    int                    cyc;
    logic [7:0]            lo;
    logic [7:0]            hi;
    logic [7:0]            cal;
    addrs = '{10'h324, 10'h325, 10'h359, 10'h000};
    st = '{aarc_pkg::radio_off_state, aarc_pkg::radio_idle_state, aarc_pkg::radio_transmit_state,
      aarc_pkg::radio_receive_state};
    void'($urandom(32'h74450600));
    rst         = 1'b1;
    radio_state = aarc_pkg::radio_off_state;
    temp_level  = 8'h00;
    rssi_level  = 8'h00;
    ext_level   = 8'h00;
    err_count   = 0;
    n_tests     = 0;
    cyc_count   = 0;
    sel_reg     = 8'h00;
    pd_reg      = 8'h00;
    aux_reg     = 8'h00;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (addrs[i]) begin
      u_host.rd(addrs[i], d, v);
      check8({7'h0, v}, 8'h01);
      check8(d, 8'h00);
    end
    check8({6'h0, adc_powered, temp_powered}, 8'h00);
    do_rb(1'b0);
    wr_reg(aarc_pkg::IN_SEL_ADDR, 8'h08);
    radio_state <= aarc_pkg::radio_receive_state;
    repeat (3) @(posedge clk);
    check8({7'h0, adc_powered}, 8'h01);
    do_rb(1'b0);
    radio_state <= aarc_pkg::radio_off_state;
    u_host.temp_setup();
    pd_reg  = 8'h10;
    sel_reg = 8'h08;
    aux_reg = 8'h02;
    u_host.rd(aarc_pkg::RX_PWRDN_ADDR, d, v);
    check8(d, 8'h10);
    check8({7'h0, temp_powered}, 8'h01);
    do_rb(1'b0);
    // Calibration sample, then a reading 19 counts above it
    temp_level <= 8'h50;
    u_host.start_conv(cyc);
    u_host.fetch(lo, hi);
    cal = {hi[7:2], lo[1:0]};
    check8(cal, 8'h50);
    temp_level <= 8'h63;
    u_host.start_conv(cyc);
    u_host.fetch(lo, hi);
    check8(8'(int'(u_host.celsius({hi[7:2], lo[1:0]}, cal, 25.0))), 8'h2B);
    for (int i = 0; i < 8; i++) begin
      radio_state <= st[i % 4];
      wr_reg(aarc_pkg::RX_PWRDN_ADDR, {3'h0, i[2] | i[0], 4'h0});
      wr_reg(aarc_pkg::IN_SEL_ADDR, {4'h0, 2'(i), 2'h0});
      u_host.wr(aarc_pkg::RES_LOWER_ADDR, 8'hFF);
      do_rb(1'b0);
    end
    u_host.rd(aarc_pkg::IN_SEL_ADDR, d, v);
    check8(d, sel_reg);
    // Reset mid-conversion must abandon the readback and clear the registers
    u_host.rd(aarc_pkg::RES_UPPER_ADDR, d, v);
    check8({7'h0, readback_busy}, 8'h01);
    repeat (4) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    pd_reg  = aarc_pkg::RX_PWRDN_RST;
    sel_reg = aarc_pkg::IN_SEL_RST;
    aux_reg = aarc_pkg::AUX_PWRDN_RST;
    @(posedge clk);
    check8({6'h0, readback_busy, temp_powered}, 8'h00);
    u_host.rd(aarc_pkg::AUX_PWRDN_ADDR, d, v);
    check8(d, aux_reg);
    wr_reg(aarc_pkg::RX_PWRDN_ADDR, 8'h10);
    do_rb(1'b1);
    close_out();
  end
endmodule : tb
